/* File: core/utx_pkg.sv */
package utx_pkg;

    // ==========================================================
    // fifo geometry
    localparam int unsigned FIFO_AW = 6;
    localparam int unsigned FIFO_DEPTH = 64;
    localparam logic [6:0] FIFO_DEPTH_W = 7'h40;

    // ==========================================================
    // register indices, byte address is index times four
    localparam logic [31:0] IDX_TX_DATA = 32'h50001852;
    localparam logic [31:0] IDX_TX_STAT = 32'h50001854;
    localparam logic [31:0] IDX_TX_CTRL = 32'h50001856;
    localparam logic [31:0] IDX_EP_CFG = 32'h50001858;
    localparam int unsigned DEC_W = 8;

    // ==========================================================
    // tx control fields
    localparam int unsigned TXC_IGN = 7;
    localparam int unsigned TXC_WL_HI = 6;
    localparam int unsigned TXC_WL_LO = 5;
    localparam int unsigned TXC_RFF = 4;
    localparam int unsigned TXC_FLUSH = 3;
    localparam int unsigned TXC_TOG = 2;
    localparam int unsigned TXC_LAST = 1;
    localparam int unsigned TXC_TXEN = 0;
    localparam logic [15:0] TXC_RST = 16'h0000;

    // ==========================================================
    // endpoint config fields
    localparam int unsigned EPC_STALL = 7;
    localparam int unsigned EPC_ISO = 5;
    localparam int unsigned EPC_EPEN = 4;
    localparam int unsigned EPC_EP_HI = 3;
    localparam logic [7:0] EPC_WMASK = 8'hBF;
    localparam logic [15:0] EPC_RST = 16'h0000;

    // ==========================================================
    // tx status fields
    localparam int unsigned STS_URUN = 7;
    localparam int unsigned STS_WARN = 6;
    localparam int unsigned STS_DONE = 5;
    localparam logic [4:0] STS_CNT_SAT = 5'h1F;

    // ==========================================================
    // warning limit codes and thresholds
    localparam logic [1:0] WL_OFF = 2'h0;
    localparam logic [1:0] WL_5 = 2'h1;
    localparam logic [1:0] WL_9 = 2'h2;
    localparam logic [6:0] LIM_5 = 7'h04;
    localparam logic [6:0] LIM_9 = 7'h08;
    localparam logic [6:0] LIM_17 = 7'h10;

    typedef enum logic [1:0] {
        TOK_OUT = 2'h0,
        TOK_IN = 2'h1,
        TOK_SETUP = 2'h2
    } utx_tok_e;

    typedef enum logic [2:0] {
        TS_IDLE = 3'h0,
        TS_DATA = 3'h1,
        TS_CRC = 3'h3,
        TS_EOP = 3'h2,
        TS_STUFF = 3'h6
    } utx_state_e;

endpackage

/* File: core/utx_ctrl.sv */
// Chosen here: the AHB-Lite slave port.
`timescale 1ns/1ps
// Behaviour
// - iso: ignore mask sends on next IN
// - warning limit codes 00 off, 01 5, 11 17
// - warning flag set at limit while enabled
// - last written saves read pointer; refill restores
// - refill waits for transmission, then self-clears
// - flush zeroes pointers after transmission, self-clears
// - non-iso toggle selects DATA0 or DATA1
// - iso transmit only when frame lsb matches toggle or ignore is set
// - missed iso frame flushed at next SOF
// - iso packets always use DATA0
// - underrun without last forces stuff error, then idle, no EOP
// - payload, CRC16, EOP, then last clears
// - tx enable clears after packet or stall
// - stall answers IN or OUT when enabled
// - SETUP never stalled by stall bit
// - enabled iso endpoint never sends NAK
// - endpoint enable gates number and address match
// - all control fields reset to zero
// - underrun flag set, cleared by status read
module utx_ctrl (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // token side of the protocol engine
    input wire logic tok_valid,
    input wire utx_pkg::utx_tok_e tok_kind,
    input wire logic [6:0] tok_addr,
    input wire logic [3:0] tok_ep,
    input wire logic sof,
    input wire logic frame_number_lsb,
    input wire logic [6:0] dev_addr,
    input wire logic rx_enabled,
    input wire logic rx_full,
    // handshake answers
    output logic hs_stall,
    output logic hs_nak,
    // packet transmit side
    output logic pkt_start,
    output logic pkt_data1,
    output logic [7:0] tx_byte,
    output logic tx_byte_valid,
    input wire logic tx_byte_ready,
    output logic tx_crc_req,
    output logic tx_eop_req,
    output logic tx_stuff_req,
    input wire logic phy_done,
    // events
    output logic tx_warning_event
);
    import utx_pkg::*;

    // ==========================================================
    // address decode
    function automatic logic reg_hit(input logic [31:0] a, input logic [31:0] idx);
        reg_hit = (a[DEC_W+1:2] == idx[DEC_W-1:0]);
    endfunction

    function automatic logic [6:0] warn_limit(input logic [1:0] code);
        case (code)
            WL_OFF: warn_limit = 7'h00;
            WL_5: warn_limit = LIM_5;
            WL_9: warn_limit = LIM_9;
            default: warn_limit = LIM_17;
        endcase
    endfunction

    logic [7:0] txc_r;
    logic [7:0] epc_r;
    logic urun_r, warn_r, done_r;
    logic [7:0] mem [FIFO_DEPTH];
    logic [FIFO_AW:0] wr_r, rd_r, save_r;
    logic match_seen_r;
    utx_state_e st_r, st_nxt;
    logic wr_pend_r, rd_pend_r;
    logic [31:0] addr_r;
    logic [31:0] rdata_nxt;
    logic [6:0] cnt;
    logic [6:0] space;
    logic [4:0] tcount;
    logic fifo_full, fifo_empty, addr_take;
    logic wr_ctrl, wr_cfg, wr_data, rd_stat;
    logic tok_match, in_hit, out_hit, iso, iso_ok, go;
    logic stall_in, nak_in, stall_out, nak_out, idle;
    logic do_flush, do_refill, iso_drop, pkt_end, pop, push, warn_set;

    // ==========================================================
    // fifo level
    assign cnt = 7'(wr_r - rd_r);
    assign space = FIFO_DEPTH_W - cnt;
    assign tcount = (space > 7'(STS_CNT_SAT)) ? STS_CNT_SAT : space[4:0];
    assign fifo_full = (cnt == FIFO_DEPTH_W);
    assign fifo_empty = (cnt == 7'h00);

    // ==========================================================
    // bus decode
    assign addr_take = hsel & hready & htrans[1];
    assign wr_ctrl = wr_pend_r & reg_hit(addr_r, IDX_TX_CTRL);
    assign wr_cfg = wr_pend_r & reg_hit(addr_r, IDX_EP_CFG);
    assign wr_data = wr_pend_r & reg_hit(addr_r, IDX_TX_DATA);
    assign rd_stat = rd_pend_r & reg_hit(addr_r, IDX_TX_STAT);
    // one wait state on reads so a write just before is seen
    assign hreadyout = ~rd_pend_r;
    assign hresp = 1'b0;

    // ==========================================================
    // token decisions
    assign iso = epc_r[EPC_ISO];
    assign tok_match = epc_r[EPC_EPEN] & (tok_addr == dev_addr)
        & (tok_ep == epc_r[EPC_EP_HI:0]);
    assign in_hit = tok_valid & tok_match & (tok_kind == TOK_IN);
    assign out_hit = tok_valid & tok_match & (tok_kind == TOK_OUT);
    assign iso_ok = ~iso | txc_r[TXC_IGN]
        | (frame_number_lsb == txc_r[TXC_TOG]);
    assign idle = (st_r == TS_IDLE);
    assign stall_in = in_hit & idle & epc_r[EPC_STALL] & txc_r[TXC_TXEN];
    assign stall_out = out_hit & epc_r[EPC_STALL] & rx_enabled;
    assign go = in_hit & idle & ~epc_r[EPC_STALL] & txc_r[TXC_TXEN] & iso_ok
        & ~txc_r[TXC_FLUSH] & ~txc_r[TXC_RFF];
    // iso endpoints stay silent when not ready
    assign nak_in = in_hit & idle & ~iso & ~epc_r[EPC_STALL] & ~txc_r[TXC_TXEN];
    assign nak_out = out_hit & ~stall_out & ~iso & rx_full;

    // ==========================================================
    // deferred fifo actions
    assign do_flush = idle & txc_r[TXC_FLUSH] & ~go;
    assign do_refill = idle & txc_r[TXC_RFF] & ~txc_r[TXC_FLUSH] & ~go;
    assign iso_drop = idle & sof & match_seen_r & txc_r[TXC_TXEN] & ~go;
    assign pkt_end = ((st_r == TS_EOP) | (st_r == TS_STUFF)) & phy_done;
    assign pop = (st_r == TS_DATA) & ~fifo_empty & (~tx_byte_valid | tx_byte_ready);
    assign push = wr_data & ~fifo_full & ~do_flush & ~iso_drop;
    assign warn_set = txc_r[TXC_TXEN] & (warn_limit(txc_r[TXC_WL_HI:TXC_WL_LO]) != 7'h00)
        & (cnt <= warn_limit(txc_r[TXC_WL_HI:TXC_WL_LO]));
    assign tx_warning_event = warn_set;
    assign tx_crc_req = (st_r == TS_CRC);
    assign tx_eop_req = (st_r == TS_EOP);
    assign tx_stuff_req = (st_r == TS_STUFF);

    // ==========================================================
    // transmit sequencer
    always_comb begin
        st_nxt = st_r;
        case (st_r)
            TS_IDLE: begin
                if (go) begin
                    st_nxt = TS_DATA;
                end
            end
            TS_DATA: begin
                if (fifo_empty & ~tx_byte_valid) begin
                    if (txc_r[TXC_LAST]) begin
                        st_nxt = TS_CRC;
                    end else begin
                        st_nxt = TS_STUFF;
                    end
                end
            end
            TS_CRC: begin
                if (phy_done) begin
                    st_nxt = TS_EOP;
                end
            end
            TS_EOP, TS_STUFF: begin
                if (phy_done) begin
                    st_nxt = TS_IDLE;
                end
            end
            default: st_nxt = TS_IDLE;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_r <= TS_IDLE;
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    // ==========================================================
    // ahb-lite phases
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            rd_pend_r <= 1'b0;
            addr_r <= 32'h00000000;
        end else if (ce) begin
            wr_pend_r <= addr_take & hwrite;
            rd_pend_r <= addr_take & ~hwrite;
            if (addr_take) begin
                addr_r <= haddr;
            end
        end
    end

    always_comb begin
        rdata_nxt = 32'h00000000;
        if (reg_hit(addr_r, IDX_TX_CTRL)) begin
            rdata_nxt[7:0] = txc_r;
        end else if (reg_hit(addr_r, IDX_EP_CFG)) begin
            rdata_nxt[7:0] = epc_r;
        end else if (reg_hit(addr_r, IDX_TX_STAT)) begin
            rdata_nxt[7:0] = {urun_r, warn_r, done_r, tcount};
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h00000000;
        end else if (ce && rd_pend_r) begin
            hrdata <= rdata_nxt;
        end
    end

    // ==========================================================
    // tx control register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            txc_r <= TXC_RST[7:0];
        end else if (ce) begin
            if (do_flush | iso_drop) begin
                txc_r[TXC_FLUSH] <= 1'b0;
                txc_r[TXC_TXEN] <= 1'b0;
                txc_r[TXC_LAST] <= 1'b0;
            end
            if (do_refill) begin
                txc_r[TXC_RFF] <= 1'b0;
            end
            if (stall_in) begin
                txc_r[TXC_TXEN] <= 1'b0;
            end
            if (pkt_end) begin
                txc_r[TXC_TXEN] <= 1'b0;
                txc_r[TXC_LAST] <= 1'b0;
            end
            // firmware write wins over a hardware clear
            if (wr_ctrl) begin
                txc_r <= hwdata[7:0];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            epc_r <= EPC_RST[7:0];
        end else if (ce && wr_cfg) begin
            epc_r <= hwdata[7:0] & EPC_WMASK;
        end
    end

    // ==========================================================
    // fifo storage and pointers
    always_ff @(posedge hclk) begin
        if (ce && push) begin
            mem[wr_r[FIFO_AW-1:0]] <= hwdata[7:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_r <= '0;
        end else if (ce) begin
            if (do_flush | iso_drop) begin
                wr_r <= '0;
            end else if (push) begin
                wr_r <= wr_r + 1'b1;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_r <= '0;
        end else if (ce) begin
            if (do_flush | iso_drop) begin
                rd_r <= '0;
            end else if (do_refill) begin
                rd_r <= save_r;
            end else if (pop) begin
                rd_r <= rd_r + 1'b1;
            end
        end
    end

    // saved pointer marks the start of the packet being closed
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            save_r <= '0;
        end else if (ce) begin
            if (do_flush | iso_drop) begin
                save_r <= '0;
            end else if (wr_ctrl && hwdata[TXC_LAST]) begin
                save_r <= rd_r;
            end
        end
    end

    // ==========================================================
    // byte output stage
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_byte <= 8'h00;
            tx_byte_valid <= 1'b0;
        end else if (ce) begin
            if (st_r != TS_DATA) begin
                tx_byte_valid <= 1'b0;
            end else if (pop) begin
                tx_byte <= mem[rd_r[FIFO_AW-1:0]];
                tx_byte_valid <= 1'b1;
            end else if (tx_byte_ready) begin
                tx_byte_valid <= 1'b0;
            end
        end
    end

    // ==========================================================
    // handshakes and packet start
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hs_stall <= 1'b0;
            hs_nak <= 1'b0;
            pkt_start <= 1'b0;
            pkt_data1 <= 1'b0;
        end else if (ce) begin
            hs_stall <= stall_in | stall_out;
            hs_nak <= nak_in | nak_out;
            pkt_start <= go;
            if (go) begin
                pkt_data1 <= ~iso & txc_r[TXC_TOG];
            end
        end
    end

    // frame match seen in this frame without an IN
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            match_seen_r <= 1'b0;
        end else if (ce) begin
            if (sof | go) begin
                match_seen_r <= 1'b0;
            end else if (iso & ~txc_r[TXC_IGN] & txc_r[TXC_TXEN] & iso_ok) begin
                match_seen_r <= 1'b1;
            end
        end
    end

    // ==========================================================
    // sticky status, set wins over read clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            urun_r <= 1'b0;
            warn_r <= 1'b0;
            done_r <= 1'b0;
        end else if (ce) begin
            if ((st_r == TS_DATA) && (st_nxt == TS_STUFF)) begin
                urun_r <= 1'b1;
            end else if (rd_stat) begin
                urun_r <= 1'b0;
            end
            if (warn_set) begin
                warn_r <= 1'b1;
            end else if (rd_stat) begin
                warn_r <= 1'b0;
            end
            if (pkt_end | stall_in | iso_drop) begin
                done_r <= 1'b1;
            end else if (rd_stat) begin
                done_r <= 1'b0;
            end
        end
    end

endmodule // utx_ctrl

/* File: test/utx_ctrl_properties.sv */
`timescale 1ns/1ps
module utx_ctrl_properties (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // bus
    input wire logic hsel,
    input wire logic hready,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hreadyout,
    input wire logic hresp,
    // tokens and answers
    input wire logic tok_valid,
    input wire utx_pkg::utx_tok_e tok_kind,
    input wire logic [6:0] tok_addr,
    input wire logic [6:0] dev_addr,
    input wire logic hs_stall,
    input wire logic hs_nak,
    input wire logic pkt_start,
    // packet steps
    input wire logic tx_crc_req,
    input wire logic tx_eop_req,
    input wire logic tx_stuff_req,
    input wire logic phy_done
);
    import utx_pkg::*;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // ==========================================================
    // sequences
    sequence rd_answer;
        !hreadyout ##1 hreadyout;
    endsequence
    sequence crc_done;
        tx_crc_req && phy_done;
    endsequence
    // ==========================================================
    // checks
    a_resp_okay: assert property (hresp == 1'h0)
        else $error("error response");
    a_read_wait: assert property (hsel && hready && htrans[1] && !hwrite |=> rd_answer)
        else $error("read wait state wrong");
    a_setup_silent: assert property (
        tok_valid && tok_kind == TOK_SETUP |=> !hs_stall && !hs_nak && !pkt_start)
        else $error("setup answered");
    a_addr_match: assert property (
        tok_valid && tok_addr != dev_addr |=> !hs_stall && !hs_nak && !pkt_start)
        else $error("foreign token answered");
    a_one_answer: assert property ($onehot0({hs_stall, hs_nak, pkt_start}))
        else $error("two answers at once");
    a_crc_eop: assert property (crc_done |=> tx_eop_req)
        else $error("no eop after crc");
    a_step_hold: assert property (tx_crc_req && !phy_done |=> tx_crc_req)
        else $error("crc step dropped early");
    a_steps_excl: assert property (
        $onehot0({tx_crc_req, tx_eop_req, tx_stuff_req}))
        else $error("two packet steps at once");
endmodule // utx_ctrl_properties

/* File: test/utx_host_model.sv */
`timescale 1ns/1ps
module utx_host_model (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // packet side
    input wire logic [7:0] tx_byte,
    input wire logic tx_byte_valid,
    output logic tx_byte_ready,
    input wire logic tx_crc_req,
    input wire logic tx_eop_req,
    input wire logic tx_stuff_req,
    output logic phy_done
);
    logic [7:0] got [$];
    logic [1:0] slot_r;
    // a real link stalls, so ready drops one cycle in four
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            slot_r <= 2'h0;
        end else begin
            slot_r <= slot_r + 2'h1;
        end
    end
    assign tx_byte_ready = slot_r != 2'h3;
    always @(posedge hclk) begin
        if (tx_byte_valid && tx_byte_ready) begin
            got.push_back(tx_byte);
        end
    end
    // each crc, eop or stuff step lasts up to four cycles
    assign phy_done = (tx_crc_req || tx_eop_req || tx_stuff_req) && slot_r == 2'h3;
endmodule // utx_host_model

/* File: test/usb_tx_endpoint_control_test.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_total++; \
    $display("[FAIL] %0t got %h exp %h", $time, (g), (e)); end end
module usb_tx_endpoint_control_test;
    import utx_pkg::*;
    localparam logic [31:0] A_DAT = IDX_TX_DATA << 2;
    localparam logic [31:0] A_STS = IDX_TX_STAT << 2;
    localparam logic [31:0] A_CTL = IDX_TX_CTRL << 2;
    localparam logic [31:0] A_EPC = IDX_EP_CFG << 2;
    logic hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0, tok_valid = 1'h0;
    logic sof = 1'h0, frame_number_lsb = 1'h0, rx_enabled = 1'h0, rx_full = 1'h0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rv;
    logic [6:0] tok_addr = 7'h2A;
    logic [3:0] tok_ep = 4'h0;
    utx_tok_e tok_kind = TOK_OUT;
    logic hreadyout, hresp, hs_stall, hs_nak, pkt_start, pkt_data1, tx_byte_valid;
    logic tx_crc_req, tx_eop_req, tx_stuff_req, tx_byte_ready, phy_done, tx_warning_event;
    logic [7:0] tx_byte;
    int err_total = 0, n_tests = 0, cyc = 0;
    logic [1:0] wc [6] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h3, 2'h3};
    int wn [6] = '{1, 4, 5, 8, 16, 17};
    logic we [6] = '{1'h0, 1'h1, 1'h0, 1'h1, 1'h1, 1'h0};
    always #5 hclk = ~hclk;
    utx_ctrl i_utx_ctrl (
        .hclk(hclk), .hresetn(hresetn), .ce(1'h1), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .tok_valid(tok_valid), .tok_kind(tok_kind), .tok_addr(tok_addr), .tok_ep(tok_ep),
        .sof(sof), .frame_number_lsb(frame_number_lsb), .dev_addr(7'h2A),
        .rx_enabled(rx_enabled), .rx_full(rx_full), .hs_stall(hs_stall), .hs_nak(hs_nak),
        .pkt_start(pkt_start), .pkt_data1(pkt_data1), .tx_byte(tx_byte),
        .tx_byte_valid(tx_byte_valid), .tx_byte_ready(tx_byte_ready),
        .tx_crc_req(tx_crc_req), .tx_eop_req(tx_eop_req), .tx_stuff_req(tx_stuff_req),
        .phy_done(phy_done), .tx_warning_event(tx_warning_event));
    utx_host_model i_utx_host_model (
        .hclk(hclk), .hresetn(hresetn), .tx_byte(tx_byte), .tx_byte_valid(tx_byte_valid),
        .tx_byte_ready(tx_byte_ready), .tx_crc_req(tx_crc_req), .tx_eop_req(tx_eop_req),
        .tx_stuff_req(tx_stuff_req), .phy_done(phy_done));
    // ==========================================================
    // bus and token tasks
    task automatic bus(input logic w, input logic [31:0] a, d, output logic [31:0] r);
        @(posedge hclk);
        hsel <= 1'h1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'h1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'h1);
        r = hrdata;
        hsel <= 1'h0;
        #1;
    endtask
    task automatic wr(input logic [31:0] a, d);
        logic [31:0] x;
        bus(1'h1, a, d, x);
    endtask
    task automatic rdc(input logic [31:0] a, e);
        logic [31:0] v;
        bus(1'h0, a, 32'h0, v);
        `CHK(v, e)
    endtask
    task automatic fill(input int n);
        for (int i = 0; i < n; i++) wr(A_DAT, 32'hA0 + i);
    endtask
    task automatic tok(input utx_tok_e k, input logic [6:0] a, input logic [3:0] e,
                       input logic [2:0] ex);
        @(posedge hclk);
        tok_valid <= 1'h1;
        tok_kind <= k;
        tok_addr <= a;
        tok_ep <= e;
        @(posedge hclk);
        tok_valid <= 1'h0;
        #1;
        `CHK({pkt_start, hs_stall, hs_nak}, ex)
    endtask
    // the wait is bounded so a stuck packet still reaches the report
    task automatic wait_end();
        int i;
        for (i = 0; i < 400; i++) begin
            @(posedge hclk);
            if ((tx_eop_req || tx_stuff_req) && phy_done) break;
        end
        `CHK(i < 400, 1'h1)
        repeat (3) @(posedge hclk);
    endtask
    task automatic chk_bytes(input int n);
        `CHK(i_utx_host_model.got.size(), n)
        for (int i = 0; i < n; i++) `CHK(i_utx_host_model.got[i], 8'hA0 + i[7:0])
        i_utx_host_model.got.delete();
    endtask
    task automatic conclude();
        $display("tests %0d errors %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            conclude();
        end
    end
    // ==========================================================
    // scenarios
    initial begin
        repeat (12) @(posedge hclk);
        hresetn <= 1'h1;
        rdc(A_CTL, 32'h0);
        rdc(A_EPC, 32'h0);
        rdc(A_STS, 32'h1F);
        rdc(32'h4, 32'h0);
        wr(A_EPC, 32'hFFFF);
        rdc(A_EPC, 32'hBF);
        wr(A_EPC, 32'h03);
        tok(TOK_IN, 7'h2A, 4'h3, 3'h0);
        wr(A_EPC, 32'h13);
        tok(TOK_IN, 7'h2A, 4'h5, 3'h0);
        tok(TOK_IN, 7'h2B, 4'h3, 3'h0);
        tok(TOK_IN, 7'h2A, 4'h3, 3'h1);
        fill(3);
        wr(A_CTL, 32'h07);
        tok(TOK_IN, 7'h2A, 4'h3, 3'h4);
        `CHK(pkt_data1, 1'h1)
        wait_end();
        chk_bytes(3);
        rdc(A_CTL, 32'h04);
        rdc(A_STS, 32'h3F);
        wr(A_CTL, 32'h10);
        rdc(A_CTL, 32'h0);
        wr(A_CTL, 32'h03);
        tok(TOK_IN, 7'h2A, 4'h3, 3'h4);
        `CHK(pkt_data1, 1'h0)
        wait_end();
        chk_bytes(3);
        wr(A_CTL, 32'h03);
        tok(TOK_IN, 7'h2A, 4'h3, 3'h4);
        wait_end();
        chk_bytes(0);
        for (int i = 0; i < 6; i++) begin
            fill(wn[i]);
            wr(A_CTL, {25'h0, wc[i], 5'h00});
            `CHK(tx_warning_event, 1'h0)
            wr(A_CTL, {25'h0, wc[i], 5'h01});
            `CHK(tx_warning_event, we[i])
            wr(A_CTL, 32'h08);
            rdc(A_CTL, 32'h0);
        end
        bus(1'h0, A_STS, 32'h0, rv);
        `CHK(rv[6], 1'h1)
        fill(1);
        wr(A_CTL, 32'h01);
        tok(TOK_IN, 7'h2A, 4'h3, 3'h4);
        wait_end();
        bus(1'h0, A_STS, 32'h0, rv);
        `CHK(rv[7], 1'h1)
        bus(1'h0, A_STS, 32'h0, rv);
        `CHK(rv[7], 1'h0)
        wr(A_EPC, 32'h93);
        wr(A_CTL, 32'h01);
        tok(TOK_IN, 7'h2A, 4'h3, 3'h2);
        rdc(A_CTL, 32'h0);
        tok(TOK_SETUP, 7'h2A, 4'h3, 3'h0);
        @(posedge hclk) rx_enabled <= 1'h1;
        tok(TOK_OUT, 7'h2A, 4'h3, 3'h2);
        @(posedge hclk) rx_enabled <= 1'h0;
        wr(A_EPC, 32'h33);
        @(posedge hclk) rx_full <= 1'h1;
        tok(TOK_OUT, 7'h2A, 4'h3, 3'h0);
        fill(1);
        wr(A_CTL, 32'h07);
        tok(TOK_IN, 7'h2A, 4'h3, 3'h0);
        @(posedge hclk) frame_number_lsb <= 1'h1;
        tok(TOK_IN, 7'h2A, 4'h3, 3'h4);
        `CHK(pkt_data1, 1'h0)
        wait_end();
        @(posedge hclk) frame_number_lsb <= 1'h0;
        fill(1);
        wr(A_CTL, 32'h87);
        tok(TOK_IN, 7'h2A, 4'h3, 3'h4);
        wait_end();
        @(posedge hclk) frame_number_lsb <= 1'h1;
        fill(1);
        wr(A_CTL, 32'h07);
        @(posedge hclk);
        sof <= 1'h1;
        @(posedge hclk);
        sof <= 1'h0;
        repeat (3) @(posedge hclk);
        rdc(A_CTL, 32'h04);
        conclude();
    end
endmodule // usb_tx_endpoint_control_test
bind utx_ctrl utx_ctrl_properties i_utx_ctrl_properties (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .hready(hready), .htrans(htrans),
    .hwrite(hwrite), .hreadyout(hreadyout), .hresp(hresp), .tok_valid(tok_valid),
    .tok_kind(tok_kind), .tok_addr(tok_addr), .dev_addr(dev_addr), .hs_stall(hs_stall),
    .hs_nak(hs_nak), .pkt_start(pkt_start), .tx_crc_req(tx_crc_req),
    .tx_eop_req(tx_eop_req), .tx_stuff_req(tx_stuff_req), .phy_done(phy_done));
